//--- rtl/dp_host.sv
`timescale 1ns/1ns
`include "dp_host_defines.svh"

// Overview of operation
// - One master chip arbitrates; controller obeys only its single wait pin.
// - Follower chip select is forced inactive while master reports wait.
// - Waiting processor finishes its cycle only after wait returns high.
// - Wait signal is sampled as a level, never as an edge.
// - Waiting side begins its read or write only after wait is removed.
// - Write pulse full minimum width is counted from wait release.
// - Follower write enable delayed at least master arbitration time.
// - Follower write delay needed only in width-expanded arrays.
// - Read-modify-write holds address and select across both halves.
module dp_host
#(
	parameter int ADDR_W = 11,
	parameter int DATA_W = 16,
	parameter bit WIDTH_EXPANDED = 1'b1,
	parameter int ARB_CYCLES = `ARB_CYCLES,
	parameter int ACCESS_CYCLES = `ACCESS_CYCLES,
	parameter int WRITE_CYCLES = `WRITE_PULSE_CYCLES
)
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic req,
	input wire logic req_write,
	input wire logic req_rmw,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [DATA_W-1:0] req_wdata,
	output logic ack,
	output logic [DATA_W-1:0] rdata,
	output logic mem_addr_oe,
	output logic [ADDR_W-1:0] mem_addr,
	output logic master_cs_n,
	output logic follower_cs_n,
	output logic master_we_n,
	output logic follower_we_n,
	output logic mem_oe_n,
	input wire logic master_busy_n,
	input wire logic [DATA_W-1:0] dq_i,
	output logic [DATA_W-1:0] dq_o,
	output logic dq_oe
);

	localparam logic [`COUNT_WIDTH-1:0] ARB_WAIT = `COUNT_WIDTH'(ARB_CYCLES + `SYNC_CYCLES);
	localparam logic [`COUNT_WIDTH-1:0] READ_WAIT = `COUNT_WIDTH'(ACCESS_CYCLES + `SYNC_CYCLES);
	localparam logic [`COUNT_WIDTH-1:0] PULSE = `COUNT_WIDTH'(WRITE_CYCLES);
	localparam logic [`COUNT_WIDTH-1:0] SLAVE_DLY = WIDTH_EXPANDED ? `COUNT_WIDTH'(ARB_CYCLES) : '0;

	// ****************************************
	// Pin sampling
	// ****************************************
	logic busy_n_s;
	logic [DATA_W-1:0] dq_s;

	// Only the master's wait pin is watched, so one arbitrator decides
	// Wait is glitchy during arbitration, so only a settled level is used
	pin_sync #(.WIDTH(1), .INIT(`PIN_INACTIVE)) u_busy_sync
	(
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.pin(master_busy_n),
		.level(busy_n_s)
	);

	pin_sync #(.WIDTH(DATA_W), .INIT('0)) u_data_sync
	(
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.pin(dq_i),
		.level(dq_s)
	);

	// ****************************************
	// Access sequencer
	// ****************************************
	dp_host_pkg::seq_state_e state_q, state_d;
	logic [`COUNT_WIDTH-1:0] cnt_q, cnt_d;
	logic [`COUNT_WIDTH-1:0] scnt_q, scnt_d;
	logic wr_q, wr_d;
	logic rmw_q, rmw_d;
	logic [DATA_W-1:0] wdata_q, wdata_d;
	logic [ADDR_W-1:0] addr_q, addr_d;
	logic addr_oe_q, addr_oe_d;
	logic cs_n_q, cs_n_d;
	logic fcs_n_q, fcs_n_d;
	logic mwe_n_q, mwe_n_d;
	logic fwe_n_q, fwe_n_d;
	logic dq_oe_q, dq_oe_d;
	logic [DATA_W-1:0] rdata_q, rdata_d;
	logic ack_q, ack_d;

	// Next values of the whole access
	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		scnt_d = scnt_q;
		wr_d = wr_q;
		rmw_d = rmw_q;
		wdata_d = wdata_q;
		addr_d = addr_q;
		addr_oe_d = addr_oe_q;
		cs_n_d = cs_n_q;
		fcs_n_d = fcs_n_q;
		mwe_n_d = mwe_n_q;
		fwe_n_d = fwe_n_q;
		dq_oe_d = dq_oe_q;
		rdata_d = rdata_q;
		ack_d = 1'b0;
		case (state_q)
			dp_host_pkg::st_idle:
			begin
				if (req)
				begin
					wr_d = req_write;
					rmw_d = req_rmw;
					wdata_d = req_wdata;
					addr_d = req_addr;
					addr_oe_d = 1'b1;
					state_d = dp_host_pkg::st_setup;
				end
			end
			dp_host_pkg::st_setup:
			begin
				// Address settles before select so arbitration sees it stable
				cs_n_d = 1'b0;
				fcs_n_d = 1'b0;
				cnt_d = ARB_WAIT;
				state_d = dp_host_pkg::st_arb;
			end
			dp_host_pkg::st_arb:
			begin
				if (cnt_q != '0)
					cnt_d = cnt_q - 1'b1;
				else if (!busy_n_s)
				begin
					fcs_n_d = 1'b1;
					state_d = dp_host_pkg::st_wait;
				end
				else if (wr_q && !rmw_q)
				begin
					mwe_n_d = 1'b0;
					dq_oe_d = 1'b1;
					cnt_d = PULSE;
					scnt_d = SLAVE_DLY;
					state_d = dp_host_pkg::st_write;
				end
				else
				begin
					cnt_d = READ_WAIT;
					state_d = dp_host_pkg::st_read;
				end
			end
			dp_host_pkg::st_wait:
			begin
				// Cycle starts only after the low level of wait is gone
				if (busy_n_s)
				begin
					fcs_n_d = 1'b0;
					if (wr_q && !rmw_q)
					begin
						mwe_n_d = 1'b0;
						dq_oe_d = 1'b1;
						cnt_d = PULSE;
						scnt_d = SLAVE_DLY;
						state_d = dp_host_pkg::st_write;
					end
					else
					begin
						cnt_d = READ_WAIT;
						state_d = dp_host_pkg::st_read;
					end
				end
			end
			dp_host_pkg::st_read:
			begin
				if (cnt_q != '0)
					cnt_d = cnt_q - 1'b1;
				else
				begin
					rdata_d = dq_s;
					if (rmw_q)
					begin
						// Select and address stay put so arbitration is kept
						rmw_d = 1'b0;
						mwe_n_d = 1'b0;
						dq_oe_d = 1'b1;
						cnt_d = PULSE;
						scnt_d = SLAVE_DLY;
						state_d = dp_host_pkg::st_write;
					end
					else
						state_d = dp_host_pkg::st_done;
				end
			end
			dp_host_pkg::st_write:
			begin
				// Follower enable trails master by the arbitration time plus one cycle when width-expanded
				if (scnt_q != '0)
					scnt_d = scnt_q - 1'b1;
				else
				begin
					fwe_n_d = 1'b0;
					if (!fwe_n_q && cnt_q > 1)
						cnt_d = cnt_q - 1'b1;
					else if (!fwe_n_q)
					begin
						mwe_n_d = 1'b1;
						fwe_n_d = 1'b1;
						state_d = dp_host_pkg::st_done;
					end
				end
			end
			dp_host_pkg::st_done:
			begin
				// Data held one cycle past write enable release
				cs_n_d = 1'b1;
				fcs_n_d = 1'b1;
				dq_oe_d = 1'b0;
				addr_oe_d = 1'b0;
				ack_d = 1'b1;
				state_d = dp_host_pkg::st_idle;
			end
			default:
				state_d = dp_host_pkg::st_idle;
		endcase
	end

	// Registers of the sequencer and all pins but mem_oe_n
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= dp_host_pkg::st_idle;
			cnt_q <= '0;
			scnt_q <= '0;
			wr_q <= 1'b0;
			rmw_q <= 1'b0;
			wdata_q <= '0;
			addr_q <= '0;
			addr_oe_q <= 1'b0;
			cs_n_q <= `PIN_INACTIVE;
			fcs_n_q <= `PIN_INACTIVE;
			mwe_n_q <= `PIN_INACTIVE;
			fwe_n_q <= `PIN_INACTIVE;
			dq_oe_q <= 1'b0;
			rdata_q <= '0;
			ack_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			scnt_q <= scnt_d;
			wr_q <= wr_d;
			rmw_q <= rmw_d;
			wdata_q <= wdata_d;
			addr_q <= addr_d;
			addr_oe_q <= addr_oe_d;
			cs_n_q <= cs_n_d;
			fcs_n_q <= fcs_n_d;
			mwe_n_q <= mwe_n_d;
			fwe_n_q <= fwe_n_d;
			dq_oe_q <= dq_oe_d;
			rdata_q <= rdata_d;
			ack_q <= ack_d;
		end
	end

	// Output enable tied active; write enable alone turns memory drivers off
	assign mem_oe_n = 1'b0;
	assign ack = ack_q;
	assign rdata = rdata_q;
	assign mem_addr = addr_q;
	assign mem_addr_oe = addr_oe_q;
	assign master_cs_n = cs_n_q;
	assign follower_cs_n = fcs_n_q;
	assign master_we_n = mwe_n_q;
	assign follower_we_n = fwe_n_q;
	assign dq_o = wdata_q;
	assign dq_oe = dq_oe_q;

	// ****************************************
	// Checks
	// ****************************************
	int unsigned fwe_low_cnt;
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			fwe_low_cnt <= 0;
		else if (!fwe_n_q)
			fwe_low_cnt <= fwe_low_cnt + 1;
		else
			fwe_low_cnt <= 0;
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence wait_seen;
		state_q == dp_host_pkg::st_wait && !busy_n_s;
	endsequence
	sequence released;
		state_q == dp_host_pkg::st_wait && busy_n_s;
	endsequence

	chk_wait_blocks_cycle: assert property (wait_seen |-> mwe_n_q && fwe_n_q)
		else $error("Write enable active while waiting");
	chk_release_starts_access: assert property (released |=> state_q inside {dp_host_pkg::st_read,
		dp_host_pkg::st_write})
		else $error("Access did not start after wait release");
	chk_follower_gated: assert property (wait_seen |-> fcs_n_q)
		else $error("Follower selected during wait");
	chk_follower_we_delay: assert property (WIDTH_EXPANDED && $fell(mwe_n_q) |-> fwe_n_q [*2])
		else $error("Follower write enable not delayed");
	chk_pulse_width: assert property ($rose(fwe_n_q) |-> fwe_low_cnt >= WRITE_CYCLES)
		else $error("Write pulse too short");
	chk_rmw_select_held: assert property ($fell(mwe_n_q) && $past(state_q) == dp_host_pkg::st_read
		|-> !cs_n_q && $stable(addr_q))
		else $error("Select dropped inside read-modify-write");
	chk_select_after_addr: assert property ($fell(cs_n_q) |-> $past(addr_oe_q))
		else $error("Select before address settled");
	chk_drive_only_writing: assert property (dq_oe_q && state_q == dp_host_pkg::st_write |-> !mwe_n_q)
		else $error("Data driven without write enable");
	chk_level_sample: assert property (state_q == dp_host_pkg::st_arb && cnt_q == '0 && !busy_n_s
		|=> state_q == dp_host_pkg::st_wait)
		else $error("Low wait level not obeyed");

endmodule

//--- rtl/dp_host_defines.svh
`ifndef DP_HOST_DEFINES_SVH
`define DP_HOST_DEFINES_SVH

// ****************************************
// Clock and pin timing
// ****************************************
// Reference clock period, ns
`define CLK_PERIOD_NS 20
// Worst-case master arbitration time, ns
`define ARBITRATION_TIME_NS 30
// Address access time of the memory, ns
`define ADDRESS_ACCESS_TIME_NS 45
// Minimum write pulse width, ns
`define WRITE_PULSE_NS 40
// Least times round up to whole cycles
`define ARB_CYCLES ((`ARBITRATION_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACCESS_CYCLES ((`ADDRESS_ACCESS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_PULSE_CYCLES ((`WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Two-flop latency of sampled pins
`define SYNC_CYCLES 2

// ****************************************
// Reset values and counter width
// ****************************************
`define PIN_INACTIVE 1'b1
`define COUNT_WIDTH 8

`endif

//--- rtl/dp_host_pkg.sv
package dp_host_pkg;

	// ****************************************
	// Sequencer states, Gray from st_idle through st_write to st_done
	// ****************************************
	typedef enum logic [2:0]
	{
		st_idle = 3'h0,
		st_setup = 3'h1,
		st_arb = 3'h3,
		st_wait = 3'h2,
		st_read = 3'h6,
		st_write = 3'h7,
		st_done = 3'h5
	} seq_state_e;

endpackage

//--- rtl/pin_sync.sv
`timescale 1ns/1ns
`include "dp_host_defines.svh"

// Two-flop synchroniser for pins from the memory
module pin_sync
#(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
)
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] pin,
	output logic [WIDTH-1:0] level
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] level_q;

	// First stage feeds only the second stage
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_q <= INIT;
			level_q <= INIT;
		end
		else
		begin
			meta_q <= pin;
			level_q <= meta_q;
		end
	end

	assign level = level_q;

endmodule

//--- testbench/dual_port_busy_master_slave_tb_top.sv
`timescale 1ns/1ns
// ****************************************
// Host controller bench
// ****************************************
module dual_port_busy_master_slave_tb_top;
	localparam int ARB = 2;
	logic ref_clk, rst_n, req, req_write, req_rmw, ack, mem_addr_oe, master_cs_n, follower_cs_n;
	logic master_we_n, follower_we_n, mem_oe_n, master_busy_n, dq_oe;
	logic [10:0] req_addr, mem_addr;
	logic [15:0] req_wdata, rdata, dq_i, dq_o;
	int busy_len, fails, checks, cycles, lat, cs_rises, gated, we_gap, plain;
	dp_host #(.ARB_CYCLES(ARB)) dp_host_inst (.ref_clk(ref_clk), .rst_n(rst_n), .req(req),
		.req_write(req_write), .req_rmw(req_rmw), .req_addr(req_addr), .req_wdata(req_wdata),
		.ack(ack), .rdata(rdata), .mem_addr_oe(mem_addr_oe), .mem_addr(mem_addr),
		.master_cs_n(master_cs_n), .follower_cs_n(follower_cs_n), .master_we_n(master_we_n),
		.follower_we_n(follower_we_n), .mem_oe_n(mem_oe_n), .master_busy_n(master_busy_n),
		.dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe));
	dual_port_model dual_port_model_inst (.ref_clk(ref_clk), .addr(mem_addr), .addr_oe(mem_addr_oe),
		.master_cs_n(master_cs_n), .follower_cs_n(follower_cs_n), .master_we_n(master_we_n),
		.follower_we_n(follower_we_n), .oe_n(mem_oe_n), .host_dq(dq_o), .host_dq_oe(dq_oe),
		.busy_len(busy_len), .busy_n(master_busy_n), .dq(dq_i));
	always #10 ref_clk = ~ref_clk;
	task give_verdict;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task check_word(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task check_bit(input logic got, input logic exp, input string what);
		check_word({15'h0, got}, {15'h0, exp}, what);
	endtask
	// One request, then watch pins each cycle until ack or a bound
	task access(input logic wr, input logic rmw, input logic [10:0] a, input logic [15:0] d);
		int t_m;
		bit cs_seen;
		@(posedge ref_clk);
		req <= 1'b1;
		req_write <= wr;
		req_rmw <= rmw;
		req_addr <= a;
		req_wdata <= d;
		@(posedge ref_clk);
		req <= 1'b0;
		{lat, cs_rises, gated} = '0;
		we_gap = -1;
		t_m = -1;
		cs_seen = 1'b0;
		while (ack !== 1'b1 && lat < 200)
		begin
			@(posedge ref_clk);
			#1;
			lat++;
			if (master_cs_n === 1'b0)
				busy_len = 0;
			if (master_cs_n === 1'b1 && cs_seen && ack !== 1'b1)
				cs_rises++;
			if (master_cs_n === 1'b0 && follower_cs_n === 1'b1)
				gated++;
			if (master_we_n === 1'b0 && t_m < 0)
				t_m = lat;
			if (follower_we_n === 1'b0 && we_gap < 0)
				we_gap = lat - t_m;
			if (master_cs_n === 1'b0)
				cs_seen = 1'b1;
		end
		check_bit(ack, 1'b1, "ack seen");
	endtask
	task test_reset;
		check_bit(master_cs_n & follower_cs_n & master_we_n & follower_we_n, 1'b1, "idle pins");
		check_bit(dq_oe | mem_addr_oe | ack, 1'b0, "idle enables");
		check_word(rdata, 16'h0000, "rdata reset");
		check_bit(mem_oe_n, 1'b0, "output enable tied");
		$display("reset test done");
	endtask
	// Boundary words written then read back, no contention
	task test_plain;
		logic [15:0] pat [3];
		logic [10:0] adr [3];
		pat = '{16'h0000, 16'hffff, 16'ha5c3};
		adr = '{11'h000, 11'h7ff, 11'h155};
		for (int i = 0; i < 3; i++)
		begin
			access(1'b1, 1'b0, adr[i], pat[i]);
			check_word(we_gap[15:0], ARB + 1, "follower write delay");
			access(1'b0, 1'b0, adr[i], 16'h0000);
			check_word(rdata, pat[i], "plain read");
			check_word(gated[15:0], 16'h0000, "follower gated");
		end
		plain = lat;
		$display("plain test done");
	endtask
	// Contention on a write, then on a read
	task test_wait;
		busy_len = 8;
		access(1'b1, 1'b0, 11'h2aa, 16'h5a3c);
		check_bit(gated > 0, 1'b1, "follower gated in wait");
		check_bit(lat > plain, 1'b1, "write held off");
		access(1'b0, 1'b0, 11'h2aa, 16'h0000);
		check_word(rdata, 16'h5a3c, "waited write stored");
		busy_len = 8;
		access(1'b0, 1'b0, 11'h2aa, 16'h0000);
		check_bit(lat > plain, 1'b1, "read held off");
		check_word(rdata, 16'h5a3c, "waited read");
		$display("wait test done");
	endtask
	// Read-modify-write keeps select low throughout
	task test_rmw;
		access(1'b1, 1'b0, 11'h3c3, 16'hbeef);
		access(1'b1, 1'b1, 11'h3c3, 16'hc0de);
		check_word(rdata, 16'hbeef, "rmw old value");
		check_word(cs_rises[15:0], 16'h0000, "select held");
		access(1'b0, 1'b0, 11'h3c3, 16'h0000);
		check_word(rdata, 16'hc0de, "rmw new value");
		$display("rmw test done");
	endtask
	// Hang guard, well above the few hundred cycles needed
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			fails++;
			give_verdict();
		end
	end
	initial
	begin
		{ref_clk, rst_n, req, req_write, req_rmw} = '0;
		req_addr = '0;
		req_wdata = '0;
		{busy_len, fails, checks, cycles} = '0;
		repeat (3) @(posedge ref_clk);
		#1;
		test_reset();
		@(posedge ref_clk);
		rst_n <= 1'b1;
		test_plain();
		test_wait();
		test_rmw();
		give_verdict();
	end
endmodule

//--- testbench/dual_port_model.sv
`timescale 1ns/1ns
// ****************************************
// Master/follower memory pair seen from one port
// ****************************************
module dual_port_model
#(
	parameter int ADDR_W = 11,
	parameter int DATA_W = 16
)
(
	input wire logic ref_clk,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic addr_oe,
	input wire logic master_cs_n,
	input wire logic follower_cs_n,
	input wire logic master_we_n,
	input wire logic follower_we_n,
	input wire logic oe_n,
	input wire logic [DATA_W-1:0] host_dq,
	input wire logic host_dq_oe,
	input wire logic [31:0] busy_len,
	output logic busy_n,
	output logic [DATA_W-1:0] dq
);
	logic [DATA_W-1:0] mem [2**ADDR_W];
	logic [DATA_W-1:0] last_q = '0;
	logic drive;
	// Drivers on for a selected read only; write enable turns them off
	assign drive = !master_cs_n && master_we_n && follower_we_n && !oe_n && addr_oe;
	// Released bus shows the inverse, never a held value
	assign dq = drive ? mem[addr] : ~last_q;
	always @(posedge ref_clk)
		if (drive)
			last_q <= mem[addr];
	initial busy_n = 1'b1;
	// Far port already holds the cell: this port loses, active low wait
	// Length captured at select, since the bench clears it right after
	// Wait falls off the clock edge, inside the arbitration time
	always @(negedge master_cs_n)
	begin
		int hold_len;
		hold_len = busy_len;
		if (hold_len > 0)
		begin
			#25 busy_n = 1'b0;
			#(hold_len * 20) busy_n = 1'b1;
		end
	end
	// Cell written at end of pulse; blocked while waiting; reader sees it next
	always @(posedge master_we_n)
		if (!master_cs_n && busy_n && host_dq_oe)
			mem[addr][DATA_W/2-1:0] = host_dq[DATA_W/2-1:0];
	// Follower takes wait as input only and obeys it
	always @(posedge follower_we_n)
		if (!follower_cs_n && busy_n && host_dq_oe)
			mem[addr][DATA_W-1:DATA_W/2] = host_dq[DATA_W-1:DATA_W/2];
endmodule
